// File: include/dtf_pkg.sv
// package for the disk task file register bank
// assumes an 8-bit multiplexed address/data bus decoded by the caller
package dtf_pkg;
  // ****************************************************
  // register addresses on the local bus
  // ****************************************************
  localparam logic [7:0] ADDR_ERR_SYNC = 8'h21; // error read, sync write
  localparam logic [7:0] ADDR_TALLY = 8'h22;
  localparam logic [7:0] ADDR_SECTOR = 8'h23;
  localparam logic [7:0] ADDR_CYL_LO = 8'h24;
  localparam logic [7:0] ADDR_CYL_HI = 8'h25;
  localparam logic [7:0] ADDR_SELECT = 8'h26;
  // ****************************************************
  // error flag bit positions
  // ****************************************************
  localparam int ERR_BAD_BLOCK = 7;
  localparam int ERR_DATA_CHECK = 6;
  localparam int ERR_RELOC = 5;
  localparam int ERR_ID_MISSING = 4;
  localparam int ERR_ABORT = 2;
  localparam int ERR_MARK = 0;
  // ****************************************************
  // select byte fields and values
  // ****************************************************
  localparam int SEL_ECC = 7;
  localparam logic [7:0] HEAD3_MASK = 8'h07;
  localparam logic [7:0] HEAD4_MASK = 8'h0f;
  localparam logic [7:0] CYL_HI_MASK = 8'h07;
  localparam logic [7:0] GAP_MASK = 8'h3f;
  localparam logic [7:0] MARK_BYTE0 = 8'ha1;
  localparam logic [7:0] MARK_BYTE1 = 8'hf8;
  // ****************************************************
  // reset values and counts
  // ****************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] IDX_RETRY = 4'd10; // index pulses with retries
  localparam logic [3:0] IDX_NORETRY = 4'd2; // index pulses, retry off
  localparam logic [2:0] RG_BYTES = 3'd2; // read gate delay in byte times
  localparam logic [1:0] GAP_SUB_SOFT = 2'd3;
  localparam logic [2:0] GAP_SUB_NRZ = 3'd6;
  // search sequencer states
  typedef enum logic [1:0] {DTF_IDLE, DTF_PASS1, DTF_PASS2} dtf_search_e;
endpackage

// File: rtl/dtf_regs.sv
// disk controller task file: error flags, sync length, sector count,
// sector number, cylinder pair, drive/head select and derived registers
// assumes bus strobes and engine events are synchronous to clk
//
// What this block does
// R1: bad block mark sets bit 7, skips data
// R2: data CRC or ECC error sets bit 6
// R3: relocation id after bad block sets bit 5
// R4: scan id misses after 10 or 2 indexes
// R5: read/write: 10 indexes, seek, 10 more
// R6: retry off: miss after 2, no seek
// R7: not ready, write fault, illegal code abort
// R8: error bits 3 and 1 read zero
// R9: read data mark not A1 F8 sets bit 0
// R10: sync length sizes data and id sync fields
// R11: parameter load copies low six sync bits
// R12: gap delay times read gate or data run
// R13: soft modes raise read gate two bytes late
// R14: tally counts sectors, 0 means 256
// R15: parameter load copies tally to gap fill
// R16: bad block returns its sector in tally
// R17: sector number targets sector or gap size
// R18: parameter load copies sector number to pad
// R19: cylinder is eleven bits, high bits zero
// R20: parameter load takes cylinder as sector size
// R21: head field three bits, four when enabled
// R22: select bit 7 picks ECC, RLL forces ECC
// R23: any error sets status error bit
`timescale 1ns/1ps
`default_nettype none
module dtf_regs (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // local bus, address already latched
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  // command engine controls
  input wire logic cmd_start,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_format,
  input wire logic cmd_scan,
  input wire logic cmd_load_params,
  input wire logic cmd_illegal,
  input wire logic retry_off,
  input wire logic reloc_enable,
  input wire logic head4_enable,
  input wire logic user_size_enable,
  input wire logic rll_mode,
  input wire logic nrz_mode,
  input wire logic hard_sector,
  // drive status pins
  input wire logic drive_ready_pin,
  input wire logic write_fault_pin,
  // disk events
  input wire logic index_pin,
  input wire logic sector_pin,
  input wire logic byte_tick,
  input wire logic bad_block_seen,
  input wire logic reloc_id_seen,
  input wire logic data_check_err,
  input wire logic id_match,
  input wire logic mark_valid,
  input wire logic [7:0] mark_b0,
  input wire logic [7:0] mark_b1,
  input wire logic sector_done,
  // derived outputs
  output logic [7:0] sync_len,
  output logic [5:0] gap_delay,
  output logic [7:0] gap_fill,
  output logic [7:0] pad_byte,
  output logic [10:0] sector_size,
  output logic [7:0] gap_len,
  output logic use_ecc,
  output logic [3:0] head_num,
  output logic skip_data,
  output logic auto_seek,
  output logic read_gate_signal,
  output logic data_run_detect,
  output logic status_error
);
  // ****************************************************
  // storage
  // ****************************************************
  logic [7:0] err_reg; // sticky error flags
  logic [7:0] tally_reg;
  logic [7:0] sector_reg;
  logic [7:0] cyl_lo_reg;
  logic [7:0] cyl_hi_reg;
  logic [7:0] select_reg;
  logic [5:0] gap_cnt_reg; // hard-sector delay counter
  logic [2:0] rg_cnt_reg;
  logic gate_run_reg;
  // pin synchronisers
  logic [1:0] rdy_sync, wf_sync, idx_sync, sec_sync;
  logic idx_q, sec_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_sync <= 2'b00;
      wf_sync <= 2'b00;
      idx_sync <= 2'b00;
      sec_sync <= 2'b00;
      idx_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      rdy_sync <= {rdy_sync[0], drive_ready_pin};
      wf_sync <= {wf_sync[0], write_fault_pin};
      idx_sync <= {idx_sync[0], index_pin};
      sec_sync <= {sec_sync[0], sector_pin};
      idx_q <= idx_sync[1];
      sec_q <= sec_sync[1];
    end
  end
  wire logic idx_rise = idx_sync[1] && !idx_q;
  wire logic sec_rise = sec_sync[1] && !sec_q;
  wire logic hs_pulse = idx_rise || sec_rise;
  // ****************************************************
  // decode
  // ****************************************************
  wire logic wr_sync = bus_wr && (bus_addr == dtf_pkg::ADDR_ERR_SYNC);
  wire logic wr_tally = bus_wr && (bus_addr == dtf_pkg::ADDR_TALLY);
  wire logic wr_sector = bus_wr && (bus_addr == dtf_pkg::ADDR_SECTOR);
  wire logic wr_cyl_lo = bus_wr && (bus_addr == dtf_pkg::ADDR_CYL_LO);
  wire logic wr_cyl_hi = bus_wr && (bus_addr == dtf_pkg::ADDR_CYL_HI);
  wire logic wr_select = bus_wr && (bus_addr == dtf_pkg::ADDR_SELECT);
  wire logic rw_cmd = cmd_read || cmd_write;
  // ****************************************************
  // search timer
  // ****************************************************
  logic id_missing_pulse;
  logic seek_pulse;
  dtf_search u_search (
    .clk(clk),
    .arst_n(arst_n),
    .start(cmd_start && (rw_cmd || cmd_scan)),
    .rw_cmd(rw_cmd),
    .retry_off(retry_off),
    .index_pulse(idx_rise),
    .id_match(id_match),
    .auto_seek(seek_pulse),
    .id_missing(id_missing_pulse),
    .busy()
  );
  // ****************************************************
  // error events
  // ****************************************************
  wire logic abort_ev = cmd_start &&
      (!rdy_sync[1] || wf_sync[1] || cmd_illegal); // [R7]
  wire logic mark_bad = cmd_read && mark_valid &&
      (mark_b0 != dtf_pkg::MARK_BYTE0 ||
       mark_b1 != dtf_pkg::MARK_BYTE1); // [R9]
  wire logic bb_ev = bad_block_seen && rw_cmd;
  logic [7:0] err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[dtf_pkg::ERR_BAD_BLOCK] = bb_ev; // [R1]
    err_set[dtf_pkg::ERR_DATA_CHECK] = data_check_err; // [R2]
    err_set[dtf_pkg::ERR_RELOC] = reloc_id_seen && reloc_enable; // [R3]
    err_set[dtf_pkg::ERR_ID_MISSING] = id_missing_pulse; // [R4] [R5]
    err_set[dtf_pkg::ERR_ABORT] = abort_ev;
    err_set[dtf_pkg::ERR_MARK] = mark_bad;
  end
  // a new command clears old flags; same-cycle events still land
  wire logic [7:0] err_next = ((cmd_start ? 8'h00 : err_reg) | err_set)
      & 8'hf5; // bits 3 and 1 never set [R8]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_reg <= dtf_pkg::RST_BYTE;
    end else begin
      err_reg <= err_next;
    end
  end
  // ****************************************************
  // sector tally and number
  // ****************************************************
  // count stays 8 bits; 0 wraps to 255, giving 256 transfers [R14]
  wire logic [7:0] tally_next = wr_tally ? bus_wdata :
      (bb_ev && reloc_enable) ? sector_reg : // [R16]
      sector_done ? tally_reg - 8'h01 : tally_reg;
  wire logic [7:0] sector_next = wr_sector ? bus_wdata :
      sector_done ? sector_reg + 8'h01 : sector_reg; // [R14] [R17]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tally_reg <= dtf_pkg::RST_BYTE;
      sector_reg <= dtf_pkg::RST_BYTE;
      cyl_lo_reg <= dtf_pkg::RST_BYTE;
      cyl_hi_reg <= dtf_pkg::RST_BYTE;
      select_reg <= dtf_pkg::RST_BYTE;
      sync_len <= dtf_pkg::RST_BYTE;
    end else begin
      tally_reg <= tally_next;
      sector_reg <= sector_next;
      if (wr_cyl_lo) begin
        cyl_lo_reg <= bus_wdata;
      end
      if (wr_cyl_hi) begin
        cyl_hi_reg <= bus_wdata & dtf_pkg::CYL_HI_MASK; // [R19]
      end
      if (wr_select) begin
        select_reg <= bus_wdata;
      end
      if (wr_sync) begin
        sync_len <= bus_wdata; // sizes sync fields [R10]
      end
    end
  end
  // ****************************************************
  // parameter block load
  // ****************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_delay <= 6'd0;
      gap_fill <= dtf_pkg::RST_BYTE;
      pad_byte <= dtf_pkg::RST_BYTE;
      sector_size <= 11'd0;
    end else if (cmd_load_params) begin
      gap_delay <= sync_len[5:0]; // [R11]
      gap_fill <= tally_reg; // [R15]
      pad_byte <= sector_reg; // [R18]
      if (user_size_enable) begin
        sector_size <= {cyl_hi_reg[2:0], cyl_lo_reg}; // [R20]
      end
    end
  end
  // ****************************************************
  // hard-sector gate timing
  // ****************************************************
  // gap delay counts byte times from the index/sector pulse [R12]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_reg <= 6'd0;
      rg_cnt_reg <= 3'd0;
      gate_run_reg <= 1'b0;
      read_gate_signal <= 1'b0;
      data_run_detect <= 1'b0;
    end else if (hard_sector && hs_pulse) begin
      gap_cnt_reg <= 6'd0;
      rg_cnt_reg <= 3'd0;
      gate_run_reg <= 1'b1;
      read_gate_signal <= 1'b0;
      data_run_detect <= !nrz_mode;
    end else if (gate_run_reg && byte_tick) begin
      if (gap_cnt_reg != gap_delay) begin
        gap_cnt_reg <= gap_cnt_reg + 6'd1;
      end
      if (rg_cnt_reg != dtf_pkg::RG_BYTES) begin
        rg_cnt_reg <= rg_cnt_reg + 3'd1;
      end
      if (nrz_mode && gap_cnt_reg + 6'd1 >= gap_delay) begin
        read_gate_signal <= 1'b1; // [R12]
      end
      if (!nrz_mode && gap_cnt_reg + 6'd1 >= gap_delay) begin
        data_run_detect <= 1'b0; // [R12]
      end
      if (!nrz_mode && rg_cnt_reg + 3'd1 == dtf_pkg::RG_BYTES) begin
        read_gate_signal <= 1'b1; // [R13]
      end
    end else if (!hard_sector) begin
      gate_run_reg <= 1'b0;
      read_gate_signal <= 1'b0;
      data_run_detect <= 1'b0;
    end
  end
  // ****************************************************
  // registered outputs and read mux
  // ****************************************************
  wire logic [7:0] head_mask = head4_enable ? dtf_pkg::HEAD4_MASK
                                            : dtf_pkg::HEAD3_MASK;
  wire logic [7:0] head_sel = select_reg & head_mask; // [R21]
  // rll always uses ecc; otherwise select bit 7 picks ecc in every command
  wire logic ecc_next = rll_mode || select_reg[dtf_pkg::SEL_ECC]; // [R22]
  wire logic [7:0] gap_sub = nrz_mode ? {5'd0, dtf_pkg::GAP_SUB_NRZ}
                                      : {6'd0, dtf_pkg::GAP_SUB_SOFT};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (bus_addr)
      dtf_pkg::ADDR_ERR_SYNC: rd_mux = err_reg;
      dtf_pkg::ADDR_TALLY: rd_mux = tally_reg;
      dtf_pkg::ADDR_SECTOR: rd_mux = sector_reg;
      dtf_pkg::ADDR_CYL_LO: rd_mux = cyl_lo_reg;
      dtf_pkg::ADDR_CYL_HI: rd_mux = cyl_hi_reg;
      dtf_pkg::ADDR_SELECT: rd_mux = select_reg;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_rdata <= 8'h00;
      use_ecc <= 1'b0;
      head_num <= 4'd0;
      gap_len <= 8'h00;
      skip_data <= 1'b0;
      auto_seek <= 1'b0;
      status_error <= 1'b0;
    end else begin
      if (bus_rd) begin
        bus_rdata <= rd_mux;
      end
      use_ecc <= ecc_next;
      head_num <= head_sel[3:0];
      gap_len <= sector_reg + gap_sub; // gap bytes from register [R17]
      skip_data <= err_next[dtf_pkg::ERR_BAD_BLOCK]; // [R1]
      auto_seek <= seek_pulse; // [R5]
      status_error <= |err_next; // [R23]
    end
  end
endmodule
`default_nettype wire

// File: rtl/dtf_search.sv
// index-pulse counting identifier search timer
// assumes index and match strobes are on clk already
`timescale 1ns/1ps
`default_nettype none
module dtf_search (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic start,
  input wire logic rw_cmd,
  input wire logic retry_off,
  input wire logic index_pulse,
  input wire logic id_match,
  // results
  output logic auto_seek,
  output logic id_missing,
  output logic busy
);
  dtf_pkg::dtf_search_e state_reg;
  logic [3:0] cnt_reg;
  wire logic [3:0] limit = retry_off ? dtf_pkg::IDX_NORETRY
                                     : dtf_pkg::IDX_RETRY;
  // second pass only for read/write with retries
  wire logic want_pass2 = rw_cmd && !retry_off;
  wire logic at_limit = index_pulse && (cnt_reg + 4'd1 == limit);
  assign busy = (state_reg != dtf_pkg::DTF_IDLE);
  // ****************************************************
  // search pass sequencer
  // ****************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= dtf_pkg::DTF_IDLE;
      cnt_reg <= 4'd0;
      auto_seek <= 1'b0;
      id_missing <= 1'b0;
    end else begin
      auto_seek <= 1'b0;
      id_missing <= 1'b0;
      unique case (state_reg)
        dtf_pkg::DTF_IDLE: begin
          cnt_reg <= 4'd0;
          if (start) begin
            state_reg <= dtf_pkg::DTF_PASS1;
          end
        end
        dtf_pkg::DTF_PASS1: begin
          if (id_match) begin
            state_reg <= dtf_pkg::DTF_IDLE;
          end else if (at_limit && want_pass2) begin
            // scan and seek, then search again [R5]
            auto_seek <= 1'b1;
            cnt_reg <= 4'd0;
            state_reg <= dtf_pkg::DTF_PASS2;
          end else if (at_limit) begin
            // retries off or a scan command: no scan or seek [R4] [R6]
            id_missing <= 1'b1;
            state_reg <= dtf_pkg::DTF_IDLE;
          end else if (index_pulse) begin
            cnt_reg <= cnt_reg + 4'd1;
          end
        end
        dtf_pkg::DTF_PASS2: begin
          if (id_match) begin
            state_reg <= dtf_pkg::DTF_IDLE;
          end else if (at_limit) begin
            id_missing <= 1'b1; // [R5]
            state_reg <= dtf_pkg::DTF_IDLE;
          end else if (index_pulse) begin
            cnt_reg <= cnt_reg + 4'd1;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sim/dtf_mcu_model.sv
// local microcontroller model: byte register cycles on the task file bus
// assumes the bank samples one-cycle strobes on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dtf_mcu_model (
  // clock
  input wire logic clk,
  // local bus
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_wr,
  output logic bus_rd,
  input wire logic [7:0] bus_rdata
);
  // idle bus, strobes low
  initial begin
    {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
  end
  // write: strobe held across one rising edge, then data inverted so a
  // late sample of a released bus cannot pass for the written byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask
  // read: data is registered at the edge that takes the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

// File: sim/dtf_regs_properties.sv
// assertions on the task file register bank ports
// assumes a bind onto dtf_regs, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dtf_regs_properties (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // local bus
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  // command and mode inputs
  input wire logic cmd_start,
  input wire logic cmd_illegal,
  input wire logic cmd_load_params,
  input wire logic retry_off,
  input wire logic head4_enable,
  input wire logic user_size_enable,
  input wire logic rll_mode,
  input wire logic bad_block_seen,
  // watched outputs
  input wire logic [7:0] sync_len,
  input wire logic [5:0] gap_delay,
  input wire logic [10:0] sector_size,
  input wire logic use_ecc,
  input wire logic [3:0] head_num,
  input wire logic skip_data,
  input wire logic auto_seek,
  input wire logic status_error
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ****************************************
  // steps of bus cycles and parameter loads
  // ****************************************
  sequence s_err_read;
    bus_rd && bus_addr == dtf_pkg::ADDR_ERR_SYNC;
  endsequence
  sequence s_sync_write;
    bus_wr && bus_addr == dtf_pkg::ADDR_ERR_SYNC;
  endsequence
  // the load edge, then the edge where copies must be visible
  sequence s_load;
    cmd_load_params ##1 1'b1;
  endsequence
  zero_bits_a: assert property (
    s_err_read |=> !bus_rdata[3] && !bus_rdata[1])
    else $error("error bits 3 or 1 read as one");
  sync_write_a: assert property (
    s_sync_write |=> sync_len == $past(bus_wdata))
    else $error("sync length missed the written byte");
  gap_copy_a: assert property (
    s_load |-> {2'b00, gap_delay} == ($past(sync_len) & dtf_pkg::GAP_MASK))
    else $error("gap delay is not the low six sync bits");
  size_hold_a: assert property (
    cmd_load_params && !user_size_enable |=> $stable(sector_size))
    else $error("sector size loaded with user size off");
  bad_block_a: assert property (
    bad_block_seen |=> skip_data && status_error)
    else $error("bad block did not flag or skip data");
  abort_a: assert property (
    cmd_start && cmd_illegal |=> status_error)
    else $error("illegal command not flagged");
  no_seek_a: assert property (
    $past(retry_off, 2) |-> !auto_seek)
    else $error("seek issued with retries off");
  head_three_a: assert property (
    !head4_enable && !$past(head4_enable) |-> !head_num[3])
    else $error("fourth head bit set in three bit mode");
  rll_ecc_a: assert property (
    rll_mode && $past(rll_mode) |-> use_ecc)
    else $error("rll mode without ecc");
endmodule
`default_nettype wire

// File: sim/dtf_regs_tb.sv
// self-checking bench for the task file register bank
// assumes the microcontroller model drives every bus cycle
`timescale 1ns/1ps
`default_nettype none
module dtf_regs_tb;
  // ****************************************
  // stimulus, observed outputs, bookkeeping
  // ****************************************
  logic clk, arst_n, cmd_start, cmd_read, cmd_write, cmd_format, cmd_scan;
  logic cmd_illegal, cmd_load_params, retry_off, reloc_enable, head4_enable;
  logic user_size_enable, rll_mode, nrz_mode, hard_sector, drive_ready_pin;
  logic write_fault_pin, index_pin, byte_tick, bad_block_seen, id_match;
  logic reloc_id_seen, data_check_err, mark_valid, sector_done, seek_seen;
  logic [7:0] mark_b0, mark_b1, s, r [8];
  logic [2:0] cause [3];
  wire logic [7:0] bus_addr, bus_wdata, bus_rdata, sync_len, gap_fill;
  wire logic [7:0] pad_byte, gap_len;
  wire logic bus_wr, bus_rd, use_ecc, skip_data, auto_seek, status_error;
  wire logic read_gate_signal, data_run_detect, sector_pin;
  wire logic [5:0] gap_delay;
  wire logic [10:0] sector_size;
  wire logic [3:0] head_num;
  int err_count, samples_checked, seed, cyc;
  // sector pulses ride on the index pulses
  assign sector_pin = index_pin;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dtf_mcu_model i_mcu (.clk, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata);
  dtf_regs i_dut (.clk, .arst_n, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .bus_rdata, .cmd_start, .cmd_read, .cmd_write, .cmd_format, .cmd_scan,
    .cmd_load_params, .cmd_illegal, .retry_off, .reloc_enable, .head4_enable,
    .user_size_enable, .rll_mode, .nrz_mode, .hard_sector, .drive_ready_pin,
    .write_fault_pin, .index_pin, .sector_pin, .byte_tick, .bad_block_seen,
    .reloc_id_seen, .data_check_err, .id_match, .mark_valid, .mark_b0,
    .mark_b1, .sector_done, .sync_len, .gap_delay, .gap_fill, .pad_byte,
    .sector_size, .gap_len, .use_ecc, .head_num, .skip_data, .auto_seek,
    .read_gate_signal, .data_run_detect, .status_error);
  // byte ticks run freely; seek pulses are latched for later checks
  always @(negedge clk) byte_tick <= ~byte_tick;
  always @(posedge clk) begin
    cyc++;
    if (auto_seek === 1'b1) seek_seen <= 1'b1;
    // the whole run needs well under a thousand cycles
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  // gap size is the programmed value plus three, six in nrz
  function automatic logic [7:0] gap_exp(logic [7:0] sec, logic nrz);
    return sec + (nrz ? 8'h06 : 8'h03);
  endfunction
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_mcu.rd(a, d);
    chk({3'h0, d}, {3'h0, e});
  endtask
  task automatic err_chk(input logic [7:0] e);
    rd_chk(dtf_pkg::ADDR_ERR_SYNC, e);
  endtask
  task automatic pulse_start();
    @(negedge clk) cmd_start = 1'b1;
    @(negedge clk) cmd_start = 1'b0;
  endtask
  task automatic pulse_load();
    @(negedge clk) cmd_load_params = 1'b1;
    @(negedge clk) cmd_load_params = 1'b0;
    @(negedge clk);
  endtask
  // index pulses long enough to clear the two-flop synchroniser
  task automatic idx(input int n);
    repeat (n) begin
      @(negedge clk) index_pin = 1'b1;
      repeat (4) @(negedge clk);
      index_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 39507;
    cause = '{3'b101, 3'b011, 3'b000};
    {cmd_start, cmd_read, cmd_write, cmd_format, cmd_scan} = '0;
    {cmd_illegal, cmd_load_params, retry_off, reloc_enable} = '0;
    {head4_enable, user_size_enable, rll_mode, nrz_mode, index_pin} = '0;
    {byte_tick, bad_block_seen, id_match, reloc_id_seen} = '0;
    {data_check_err, mark_valid, sector_done, seek_seen} = '0;
    {write_fault_pin, mark_b0, mark_b1} = '0;
    {hard_sector, drive_ready_pin, arst_n} = 3'b110;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    // random bytes written back to back, cylinder high kept to three bits
    for (int a = 2; a < 7; a++) begin
      r[a] = 8'($random(seed));
      if (a == 5) r[a] = r[a] & dtf_pkg::CYL_HI_MASK;
      i_mcu.wr(8'(32 + a), r[a]);
    end
    for (int a = 2; a < 7; a++) rd_chk(8'(32 + a), r[a]);
    rd_chk(8'h40, 8'h00);
    $display("test registers done");
    s = 8'($random(seed));
    i_mcu.wr(dtf_pkg::ADDR_ERR_SYNC, s);
    user_size_enable = 1'b1;
    pulse_load();
    chk(11'(gap_delay), 11'(s & dtf_pkg::GAP_MASK));
    chk(11'(sync_len), 11'(s));
    chk(11'(gap_fill), 11'(r[2]));
    chk(11'(pad_byte), 11'(r[3]));
    chk(sector_size, {r[5][2:0], r[4]});
    chk(11'(gap_len), 11'(gap_exp(r[3], 1'b0)));
    chk(11'(head_num), 11'(r[6] & dtf_pkg::HEAD3_MASK));
    chk(11'(use_ecc), 11'(r[6][7]));
    // user size off: the cylinder pair must not reach the size register
    {nrz_mode, user_size_enable} = 2'b10;
    i_mcu.wr(dtf_pkg::ADDR_CYL_LO, ~r[4]);
    pulse_load();
    chk(sector_size, {r[5][2:0], r[4]});
    chk(11'(gap_len), 11'(gap_exp(r[3], 1'b1)));
    $display("test parameter load done");
    pulse_start();
    err_chk(8'h00);
    for (int k = 0; k < 3; k++) begin
      {cmd_illegal, write_fault_pin, drive_ready_pin} = cause[k];
      repeat (4) @(negedge clk);
      pulse_start();
      {cmd_illegal, write_fault_pin, drive_ready_pin} = 3'b001;
      repeat (4) @(negedge clk);
      err_chk(8'h04);
      chk(11'(status_error), 11'h1);
    end
    $display("test abort done");
    {cmd_read, reloc_enable} = 2'b11;
    i_mcu.wr(dtf_pkg::ADDR_SECTOR, s);
    pulse_start();
    @(negedge clk) bad_block_seen = 1'b1;
    @(negedge clk) bad_block_seen = 1'b0;
    reloc_id_seen = 1'b1;
    @(negedge clk) reloc_id_seen = 1'b0;
    repeat (2) @(negedge clk);
    err_chk(8'ha0);
    rd_chk(dtf_pkg::ADDR_TALLY, s);
    chk(11'(skip_data), 11'h1);
    // a bad data mark only counts in reads
    for (int k = 0; k < 2; k++) begin
      {cmd_read, cmd_write} = k ? 2'b01 : 2'b10;
      pulse_start();
      {mark_b0, mark_b1} = {dtf_pkg::MARK_BYTE0, 8'($random(seed)) | 8'h01};
      @(negedge clk) {data_check_err, mark_valid} = 2'b11;
      @(negedge clk) {data_check_err, mark_valid} = 2'b00;
      repeat (2) @(negedge clk);
      err_chk(k ? 8'h40 : 8'h41);
    end
    {cmd_read, cmd_write, reloc_enable} = '0;
    $display("test error flags done");
    i_mcu.wr(dtf_pkg::ADDR_TALLY, 8'h00);
    i_mcu.wr(dtf_pkg::ADDR_SECTOR, 8'hff);
    @(negedge clk) sector_done = 1'b1;
    @(negedge clk) sector_done = 1'b0;
    rd_chk(dtf_pkg::ADDR_TALLY, 8'hff);
    rd_chk(dtf_pkg::ADDR_SECTOR, 8'h00);
    $display("test sector step done");
    retry_off = 1'b1;
    for (int k = 0; k < 2; k++) begin
      {cmd_scan, cmd_write} = k ? 2'b01 : 2'b10;
      pulse_start();
      idx(2);
      err_chk(8'h10);
    end
    chk(11'(seek_seen), 11'h0);
    retry_off = 1'b0;
    pulse_start();
    idx(10);
    chk(11'(seek_seen), 11'h1);
    err_chk(8'h00);
    idx(10);
    err_chk(8'h10);
    {cmd_scan, cmd_write} = 2'b10;
    pulse_start();
    idx(9);
    err_chk(8'h00);
    idx(1);
    err_chk(8'h10);
    $display("test search done");
    i_mcu.wr(dtf_pkg::ADDR_ERR_SYNC, 8'h3f);
    pulse_load();
    for (int k = 0; k < 2; k++) begin
      nrz_mode = k[0];
      idx(1);
      chk(11'(read_gate_signal), 11'(!k));
      chk(11'(data_run_detect), 11'(!k));
      repeat (130) @(negedge clk);
      chk(11'(read_gate_signal), 11'h1);
      chk(11'(data_run_detect), 11'h0);
    end
    $display("test gate timing done");
    {head4_enable, rll_mode} = 2'b11;
    i_mcu.wr(dtf_pkg::ADDR_SELECT, 8'h0f);
    repeat (2) @(negedge clk);
    chk(11'(head_num), 11'h00f);
    chk(11'(use_ecc), 11'h1);
    $display("test head and ecc done");
    give_verdict();
  end
endmodule
bind dtf_regs dtf_regs_properties i_chk (.clk, .arst_n, .bus_addr, .bus_wdata,
  .bus_wr, .bus_rd, .bus_rdata, .cmd_start, .cmd_illegal, .cmd_load_params,
  .retry_off, .head4_enable, .user_size_enable, .rll_mode, .bad_block_seen,
  .sync_len, .gap_delay, .sector_size, .use_ecc, .head_num, .skip_data,
  .auto_seek, .status_error);
`default_nettype wire
